// file: src/mis_pkg.sv
// Summary of operation
// RULE_01: Rounding other than one snaps the reading to the nearest increment multiple.
// RULE_02: Rounding works from the least significant digit of the reading.
// RULE_03: Changing rounding leaves scaling points and setpoints untouched.
// RULE_04: A signed offset, -19999 to 99999, is added; zero changes nothing.
// RULE_05: A zero-display command rewrites the offset to the new display shift.
// RULE_06: Filter time constant in tenths of a second, 0 to 25.0; zero bypasses.
// RULE_07: A step settles to about 99% within roughly three time constants; the code needs about five, tau being 2^k samples.
// RULE_08: Filter disengages while variation exceeds the band, re-engages below it.
// RULE_09: A band of zero keeps the filter engaged always.
// RULE_10: Ice point slope serves only the custom thermocouple type.
// RULE_11: An ice point slope of zero turns cold-junction compensation off.
// RULE_12: Up to 16 scaling points, input and display, each -19999 to 99999.
// RULE_13: Linear interpolation between consecutive points in programmed order.
// RULE_14: Beyond the last point, extrapolate with the slope of the final pair.
// RULE_15: Extrapolation stops at the limits of the selected input range.
// RULE_16: Scaled spread limited to 65535 counts, half per polarity.
// RULE_17: After a live-capture pass the style returns to keyed; values stay.
// RULE_18: Live capture: enter key stores live input, advance key skips.
// RULE_19: Operator must not map one input value to two display values.
// RULE_20: Decimal point governs main displays; running sum has its own.
// RULE_21: Temperature scale applies to main and sum displays; not for custom.
// RULE_22: Custom sensor hides scale, widens decimal choices, needs points.
// RULE_23: Enter key stores and activates the shown value, then advances.
// RULE_24: First-order recursive filter, one update per sample, from time constant.
// RULE_25: Order is scaling, filtering, offset, rounding; one output per sample.
package mis_pkg;
  localparam int VW = 24;
  localparam int AW = 8;
  typedef logic signed [VW-1:0] mis_val_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mis_bus_type;

  typedef enum logic [1:0] {
    MIS_PROCESS, MIS_TC_STD, MIS_TC_CUSTOM, MIS_RTD_CUSTOM
  } mis_sens_type;

  typedef struct packed {
    logic [2:0] tot_dp;
    logic tscale;
    logic [2:0] dp;
    mis_sens_type sens;
    logic live_style;
  } mis_cfg_type;

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_NPTS = 8'h04;
  localparam logic [AW-1:0] A_ROUND = 8'h08;
  localparam logic [AW-1:0] A_OFFSET = 8'h0C;
  localparam logic [AW-1:0] A_FTC = 8'h10;
  localparam logic [AW-1:0] A_FBAND = 8'h14;
  localparam logic [AW-1:0] A_ICE = 8'h18;
  localparam logic [AW-1:0] A_KEY = 8'h1C;
  localparam logic [AW-1:0] A_KVAL = 8'h20;
  localparam logic [AW-1:0] A_STAT = 8'h24;
  localparam logic [AW-1:0] A_DISP = 8'h28;
  localparam logic [AW-1:0] A_LIVE = 8'h2C;
  localparam logic [AW-1:0] A_PIN = 8'h40;
  localparam logic [AW-1:0] A_PDSP = 8'h80;

  localparam int KEY_ENTER = 0;
  localparam int KEY_ADV = 1;
  localparam int KEY_ZERO = 2;

  localparam int NPTS_MAX = 16;
  localparam logic [4:0] NPTS_MIN = 5'h02;
  localparam logic [4:0] NPTS_RST = 5'h02;
  localparam logic [7:0] ROUND_RST = 8'h01;
  localparam logic [7:0] FTC_RST = 8'h0A;
  localparam logic [7:0] FTC_MAX = 8'hFA;
  localparam logic [7:0] FBAND_RST = 8'h0A;
  localparam logic [7:0] FBAND_MAX = 8'hFA;
  localparam mis_val_type VAL_MIN = -24'sd19999;
  localparam mis_val_type VAL_MAX = 24'sd99999;
  localparam logic [15:0] HALF_SPREAD = 16'h7FFF;
  localparam int FRAC = 8;
  localparam int TENTHS = 10;
endpackage

// file: src/mis_div.sv
`timescale 1ns/1ps
module mis_div #(
  parameter int NW = 48,
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Request
  input wire logic start,
  input wire logic signed [NW-1:0] num,
  input wire logic signed [DW-1:0] den,
  // Answer
  output logic done,
  output logic signed [NW-1:0] quo
);
  logic [NW-1:0] n_q;
  logic [DW:0] r_q;
  logic [DW-1:0] d_q;
  logic neg_q;
  logic busy_q;
  logic [$clog2(NW+1)-1:0] cnt_q;
  logic [DW:0] r_sh;

  assign r_sh = {r_q[DW-1:0], n_q[NW-1]};

  // Restoring division on magnitudes, sign fixed up at the end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      n_q <= '0;
      r_q <= '0;
      d_q <= '0;
      neg_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
      done <= 1'b0;
      quo <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        n_q <= num[NW-1] ? NW'(-num) : num;
        d_q <= den[DW-1] ? DW'(-den) : den;
        neg_q <= num[NW-1] ^ den[DW-1];
        r_q <= '0;
        cnt_q <= '0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (r_sh >= {1'b0, d_q}) begin
          r_q <= r_sh - {1'b0, d_q};
          n_q <= {n_q[NW-2:0], 1'b1};
        end else begin
          r_q <= r_sh;
          n_q <= {n_q[NW-2:0], 1'b0};
        end
        cnt_q <= cnt_q + 1'b1;
        if (32'(cnt_q) == NW - 1) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          quo <= neg_q ? NW'(-$signed({n_q[NW-2:0], r_sh >= {1'b0, d_q}}))
                       : $signed({n_q[NW-2:0], r_sh >= {1'b0, d_q}});
        end
      end
    end
  end
endmodule // mis_div

// file: src/mis_top.sv
`timescale 1ns/1ps
module mis_top #(
  parameter int SAMPLE_HZ = 20,
  parameter logic signed [23:0] RANGE_MIN = -24'sd20000,
  parameter logic signed [23:0] RANGE_MAX = 24'sd20000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire mis_pkg::mis_bus_type bus,
  output logic [31:0] rd_data,
  // Converter sample stream
  input wire logic adc_valid,
  input wire mis_pkg::mis_val_type adc_data,
  output logic adc_ready,
  // Cold-junction inputs
  input wire logic signed [15:0] cj_temp,
  input wire mis_pkg::mis_val_type cj_std_comp,
  // Display side
  output logic disp_valid,
  output mis_pkg::mis_val_type disp_value,
  output logic [2:0] disp_dp,
  output logic [2:0] tot_dp,
  output logic temp_scale,
  output logic scale_shown,
  output logic points_needed
);
  import mis_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SEARCH, S_SDIV, S_FILT, S_OFFS, S_RDIV, S_OUT
  } mis_state_type;

  function automatic mis_val_type sat(input logic signed [47:0] v);
    if (v < 48'(VAL_MIN)) return VAL_MIN;
    if (v > 48'(VAL_MAX)) return VAL_MAX;
    return v[VW-1:0];
  endfunction

  function automatic logic between(input mis_val_type x, a, b);
    return (x >= a && x <= b) || (x <= a && x >= b);
  endfunction

  function automatic logic [3:0] fshift(input logic [7:0] tc);
    logic [31:0] n;
    logic [3:0] k;
    n = 32'(tc) * 32'(SAMPLE_HZ) / TENTHS;
    k = '0;
    for (int i = 0; i < 15; i++) begin
      if ((32'h1 << k) < n) k = k + 1'b1;
    end
    return k;
  endfunction

  mis_cfg_type cfg_q;
  logic [4:0] npts_q;
  logic [7:0] round_q, ftc_q, fband_q;
  logic signed [15:0] ice_q;
  mis_val_type offset_q, kval_q, live_q;
  mis_val_type pin_q [NPTS_MAX];
  mis_val_type pdp_q [NPTS_MAX];
  logic [3:0] cap_q;
  mis_state_type st_q;
  logic [3:0] idx_q;
  mis_val_type x_q, sc_q, ofv_q, res_q;
  logic signed [31:0] acc_q;
  logic bypass_q;
  logic div_start_q, div_done;
  logic signed [47:0] div_num_q, div_quo;
  mis_val_type div_den_q;

  logic key_wr, k_enter, k_adv, k_zero, cap_last, custom, scaling;
  mis_val_type comp, raw, ofs_sum;
  logic signed [31:0] xs, diff;
  logic [39:0] adiff;
  logic signed [24:0] lim;
  logic signed [47:0] scaled;

  assign key_wr = bus.wr && bus.addr == A_KEY;
  assign k_enter = key_wr && bus.wdata[KEY_ENTER];
  assign k_adv = key_wr && bus.wdata[KEY_ADV] && !bus.wdata[KEY_ENTER];
  assign k_zero = key_wr && bus.wdata[KEY_ZERO];
  assign cap_last = (k_enter || k_adv) && {1'b0, cap_q} == npts_q - 1'b1;
  assign custom = cfg_q.sens inside {MIS_TC_CUSTOM, MIS_RTD_CUSTOM};
  assign scaling = cfg_q.sens != MIS_TC_STD && npts_q >= NPTS_MIN;

  // Slope compensation only for the custom couple, none at slope zero
  always_comb begin
    comp = '0;
    if (cfg_q.sens == MIS_TC_CUSTOM && ice_q != '0) // [RULE_10] [RULE_11]
      comp = VW'(32'(ice_q) * 32'(cj_temp));
    else if (cfg_q.sens == MIS_TC_STD) // [RULE_10]
      comp = cj_std_comp;
  end
  assign raw = VW'(adc_data + comp);

  // Configuration registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '0;
      npts_q <= NPTS_RST;
      round_q <= ROUND_RST;
      offset_q <= '0;
      ftc_q <= FTC_RST;
      fband_q <= FBAND_RST;
      ice_q <= '0;
      kval_q <= '0;
    end else begin
      if (bus.wr) begin
        unique case (bus.addr)
          A_CTRL: begin
            cfg_q <= bus.wdata[$bits(mis_cfg_type)-1:0];
            // Decimal choices widen only for custom sensors
            if (!(bus.wdata[2:1] inside {2'(MIS_TC_CUSTOM),
                2'(MIS_RTD_CUSTOM)}) && bus.wdata[5:3] > 3'h1)
              cfg_q.dp <= 3'h1; // [RULE_22]
          end
          A_NPTS: npts_q <= bus.wdata[4:0] > 5'(NPTS_MAX) ? 5'(NPTS_MAX) :
                            bus.wdata[4:0] < NPTS_MIN ? NPTS_MIN :
                            bus.wdata[4:0]; // [RULE_12]
          // Table untouched on purpose; rounding is display-only
          A_ROUND: round_q <= bus.wdata[7:0] == '0 ? ROUND_RST :
                              bus.wdata[7:0]; // [RULE_03]
          A_OFFSET: offset_q <= sat(48'($signed(bus.wdata))); // [RULE_04]
          A_FTC: ftc_q <= bus.wdata[7:0] > FTC_MAX ? FTC_MAX :
                          bus.wdata[7:0]; // [RULE_06]
          A_FBAND: fband_q <= bus.wdata[7:0] > FBAND_MAX ? FBAND_MAX :
                              bus.wdata[7:0]; // [RULE_08]
          A_ICE: ice_q <= bus.wdata[15:0];
          A_KVAL: kval_q <= sat(48'($signed(bus.wdata)));
          default: ;
        endcase
      end
      if (k_zero)
        offset_q <= sat(48'(offset_q) - 48'(disp_value)); // [RULE_05]
      if (cfg_q.live_style && cap_last)
        cfg_q.live_style <= 1'b0; // [RULE_17]
    end
  end

  // Point table, written by software or by the enter key
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NPTS_MAX; i++) begin
        pin_q[i] <= '0;
        pdp_q[i] <= '0;
      end
    end else begin
      if (bus.wr && bus.addr[7:6] == A_PIN[7:6])
        pin_q[bus.addr[5:2]] <= sat(48'($signed(bus.wdata))); // [RULE_12]
      if (bus.wr && bus.addr[7:6] == A_PDSP[7:6])
        pdp_q[bus.addr[5:2]] <= sat(48'($signed(bus.wdata))); // [RULE_12]
      if (k_enter)
        pin_q[cap_q] <= cfg_q.live_style ? live_q : kval_q; // [RULE_18] [RULE_23]
    end
  end

  // Point being entered; advances on either key
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cap_q <= '0;
    end else if (bus.wr && bus.addr == A_CTRL) begin
      cap_q <= '0;
    end else if (k_enter || k_adv) begin
      cap_q <= cap_last ? 4'h0 : cap_q + 1'b1; // [RULE_18] [RULE_23]
    end
  end

  // Live reading for capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) live_q <= '0;
    else if (adc_valid) live_q <= raw;
  end

  assign lim = 25'($signed({1'b0, HALF_SPREAD}) * $signed({1'b0, round_q}));
  assign scaled = 48'(pdp_q[idx_q]) + div_quo;
  assign xs = 32'(sc_q) <<< FRAC;
  assign diff = xs - acc_q;
  assign adiff = diff[31] ? 40'(-diff) : 40'(diff);
  assign ofs_sum = VW'(acc_q >>> FRAC) + offset_q;

  mis_div #(
    .NW(48),
    .DW(VW)
  ) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(div_start_q),
    .num(div_num_q),
    .den(div_den_q),
    .done(div_done),
    .quo(div_quo)
  );

  // Sample pipeline, one result per accepted sample
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      idx_q <= '0;
      x_q <= '0;
      sc_q <= '0;
      ofv_q <= '0;
      res_q <= '0;
      acc_q <= '0;
      bypass_q <= 1'b0;
      div_start_q <= 1'b0;
      div_num_q <= '0;
      div_den_q <= '0;
      adc_ready <= 1'b0;
      disp_valid <= 1'b0;
      disp_value <= '0;
    end else begin
      div_start_q <= 1'b0;
      disp_valid <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          adc_ready <= 1'b1;
          if (adc_valid && adc_ready) begin
            adc_ready <= 1'b0;
            // Clamp at range limits stops extrapolation there
            x_q <= raw < RANGE_MIN ? RANGE_MIN :
                   raw > RANGE_MAX ? RANGE_MAX : raw; // [RULE_15]
            idx_q <= '0;
            st_q <= scaling ? S_SEARCH : S_FILT; // [RULE_25]
            if (!scaling) sc_q <= raw;
          end
        end
        S_SEARCH: begin
          // Segments in program order; last pair also extrapolates
          if (between(x_q, pin_q[idx_q], pin_q[idx_q + 1'b1]) ||
              {1'b0, idx_q} == npts_q - 5'h2) begin // [RULE_13] [RULE_14]
            if (pin_q[idx_q + 1'b1] == pin_q[idx_q]) begin
              sc_q <= pdp_q[idx_q];
              st_q <= S_FILT;
            end else begin
              div_num_q <= 48'(x_q - pin_q[idx_q]) *
                           48'(pdp_q[idx_q + 1'b1] - pdp_q[idx_q]);
              div_den_q <= pin_q[idx_q + 1'b1] - pin_q[idx_q];
              div_start_q <= 1'b1;
              st_q <= S_SDIV;
            end
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        S_SDIV: if (div_done) begin
          sc_q <= scaled > 48'(lim) ? VW'(lim) :
                  scaled < -48'(lim) ? VW'(-lim) : scaled[VW-1:0]; // [RULE_16]
          st_q <= S_FILT;
        end
        S_FILT: begin
          if (ftc_q == '0 || (fband_q != '0 &&
              adiff * 40'(TENTHS) > (40'(fband_q) << FRAC))) begin
            acc_q <= xs; // [RULE_06] [RULE_08] [RULE_09]
            bypass_q <= 1'b1;
          end else begin
            // Step 2^-k per sample, tau ~ 2^k samples
            acc_q <= acc_q + (diff >>> fshift(ftc_q)); // [RULE_24] [RULE_07]
            bypass_q <= 1'b0;
          end
          st_q <= S_OFFS;
        end
        S_OFFS: begin
          ofv_q <= ofs_sum; // [RULE_04]
          // Operands set with start, so the divider never sees stale ones
          div_num_q <= (ofs_sum[VW-1] ? 48'(-ofs_sum) : 48'(ofs_sum)) +
                       48'(round_q >> 1); // [RULE_01] [RULE_02]
          div_den_q <= VW'(round_q);
          div_start_q <= round_q != 8'h01;
          st_q <= round_q == 8'h01 ? S_OUT : S_RDIV;
        end
        S_RDIV: begin
          if (div_done) begin
            // Magnitude was rounded, sign goes back on here
            res_q <= ofv_q[VW-1] ? VW'(-(div_quo * 48'(round_q))) :
                     VW'(div_quo * 48'(round_q)); // [RULE_01]
            st_q <= S_OUT;
          end
        end
        S_OUT: begin
          disp_value <= round_q == 8'h01 ? ofv_q : res_q; // [RULE_25]
          disp_valid <= 1'b1;
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Display attributes and register reads
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
      disp_dp <= '0;
      tot_dp <= '0;
      temp_scale <= 1'b0;
      scale_shown <= 1'b0;
      points_needed <= 1'b0;
    end else begin
      disp_dp <= cfg_q.dp; // [RULE_20]
      tot_dp <= cfg_q.tot_dp; // [RULE_20]
      temp_scale <= custom ? 1'b0 : cfg_q.tscale; // [RULE_21]
      scale_shown <= cfg_q.sens == MIS_TC_STD; // [RULE_21] [RULE_22]
      // Untouched table has equal first inputs
      points_needed <= custom && pin_q[0] == pin_q[1]; // [RULE_22]
      rd_data <= '0;
      if (bus.rd) begin
        unique case (bus.addr)
          A_CTRL: rd_data <= 32'(cfg_q);
          A_NPTS: rd_data <= 32'(npts_q);
          A_ROUND: rd_data <= 32'(round_q);
          A_OFFSET: rd_data <= 32'(offset_q);
          A_FTC: rd_data <= 32'(ftc_q);
          A_FBAND: rd_data <= 32'(fband_q);
          A_ICE: rd_data <= 32'(ice_q);
          A_KVAL: rd_data <= 32'(kval_q);
          A_STAT: rd_data <= {25'h0, bypass_q, cap_q, points_needed,
                              st_q != S_IDLE};
          A_DISP: rd_data <= 32'(disp_value);
          A_LIVE: rd_data <= 32'(live_q);
          default: begin
            if (bus.addr[7:6] == A_PIN[7:6])
              rd_data <= 32'(pin_q[bus.addr[5:2]]);
            else if (bus.addr[7:6] == A_PDSP[7:6])
              rd_data <= 32'(pdp_q[bus.addr[5:2]]);
          end
        endcase
      end
    end
  end
endmodule // mis_top

// file: sim/mis_top_monitor.sv
`timescale 1ns/1ps
module mis_top_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire mis_pkg::mis_bus_type bus,
  input wire logic [31:0] rd_data,
  // Sample stream
  input wire logic adc_valid,
  input wire logic adc_ready,
  // Display side
  input wire logic disp_valid,
  input wire mis_pkg::mis_val_type disp_value,
  input wire logic [2:0] disp_dp,
  input wire logic [2:0] tot_dp,
  input wire logic scale_shown
);
  import mis_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    adc_valid && adc_ready;
  endsequence
  sequence s_ctrl;
    bus.wr && bus.addr == A_CTRL;
  endsequence
  sequence s_custom;
    s_ctrl ##0 bus.wdata[2];
  endsequence
  property p_take;
    s_take |=> !adc_ready;
  endproperty
  a_take: assert property (p_take) else $error("ready high after take");
  property p_result;
    s_take |-> ##[3:300] disp_valid;
  endproperty
  a_result: assert property (p_result) else $error("no result");
  property p_pulse;
    disp_valid |=> !disp_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_hold;
    !disp_valid |-> $stable(disp_value);
  endproperty
  a_hold: assert property (p_hold) else $error("value moved");
  property p_free;
    disp_valid |-> !adc_ready ##[1:3] adc_ready;
  endproperty
  a_free: assert property (p_free) else $error("ready not back");
  property p_dp;
    s_custom |-> ##2 disp_dp == $past(bus.wdata[5:3], 2) && !scale_shown;
  endproperty
  a_dp: assert property (p_dp) else $error("custom dp");
  property p_tot;
    s_ctrl |-> ##2 tot_dp == $past(bus.wdata[9:7], 2);
  endproperty
  a_tot: assert property (p_tot) else $error("sum dp");
  property p_rd;
    bus.rd && bus.addr == A_DISP |=> rd_data == 32'($past(disp_value));
  endproperty
  a_rd: assert property (p_rd) else $error("display read");
  property p_idle;
    !bus.rd |=> rd_data == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule // mis_top_monitor

bind mis_top mis_top_monitor i_mis_top_monitor (
  .core_clk(core_clk), .nrst(nrst), .bus(bus), .rd_data(rd_data),
  .adc_valid(adc_valid), .adc_ready(adc_ready), .disp_valid(disp_valid),
  .disp_value(disp_value), .disp_dp(disp_dp), .tot_dp(tot_dp),
  .scale_shown(scale_shown));

// file: sim/mis_adc_model.sv
`timescale 1ns/1ps
module mis_adc_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Sample stream
  input wire logic adc_ready,
  output logic adc_valid,
  output mis_pkg::mis_val_type adc_data
);
  import mis_pkg::*;
  mis_val_type q[$];
  int gap = 0;
  int idle_q;
  // Sample held until taken; data toggles otherwise so stale never matches
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc_valid <= 1'b0;
      adc_data <= '0;
      idle_q <= 0;
    end else if (adc_valid && adc_ready) begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      idle_q <= 0;
    end else if (!adc_valid && q.size() > 0 && idle_q >= gap) begin
      adc_valid <= 1'b1;
      adc_data <= q.pop_front();
    end else if (!adc_valid) begin
      adc_data <= ~adc_data;
      idle_q <= idle_q + 1;
    end
  end
endmodule // mis_adc_model

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mis_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  mis_bus_type bus = '0;
  logic [31:0] rd_data;
  logic adc_valid;
  logic adc_ready;
  mis_val_type adc_data;
  logic signed [15:0] cj_temp = 16'sh0019;
  mis_val_type cj_std_comp = 24'sh000007;
  logic disp_valid;
  mis_val_type disp_value;
  logic [2:0] disp_dp;
  logic [2:0] tot_dp;
  logic temp_scale;
  logic scale_shown;
  logic points_needed;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  mis_val_type got;

  always #10 core_clk = ~core_clk;

  mis_top i_mis_top (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .rd_data(rd_data), .adc_valid(adc_valid), .adc_data(adc_data),
    .adc_ready(adc_ready), .cj_temp(cj_temp), .cj_std_comp(cj_std_comp),
    .disp_valid(disp_valid), .disp_value(disp_value), .disp_dp(disp_dp),
    .tot_dp(tot_dp), .temp_scale(temp_scale), .scale_shown(scale_shown),
    .points_needed(points_needed));

  mis_adc_model i_mis_adc_model (.core_clk(core_clk), .nrst(nrst),
    .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_data(adc_data));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    chk(what, rd_data, exp);
  endtask

  task automatic take(output mis_val_type v);
    int n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (disp_valid !== 1'b1 && n < 400);
    chk("valid", {31'h0, disp_valid}, 32'h1);
    v = disp_value;
  endtask

  task automatic run(input string what, input mis_val_type x,
                     input mis_val_type exp);
    i_mis_adc_model.q.push_back(x);
    take(got);
    chk(what, 32'(got), 32'(exp));
  endtask

  task automatic close_out();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bounds a hang; whole run needs roughly a fifth of this
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rdc("ctrl", A_CTRL, 32'h0);
    rdc("npts", A_NPTS, 32'h2);
    rdc("round", A_ROUND, 32'h1);
    rdc("offset", A_OFFSET, 32'h0);
    rdc("ftc", A_FTC, 32'hA);
    rdc("fband", A_FBAND, 32'hA);
    rdc("ice", A_ICE, 32'h0);
    wr(8'h30, 32'h5);
    rdc("unmapped", 8'h30, 32'h0);
    wr(A_CTRL, 32'h4);
    rdc("needed", A_STAT, 32'h2);
    chk("needed_pin", {31'h0, points_needed}, 32'h1);
    wr(A_CTRL, 32'h0);
    // Distinct inputs per point, as the operator must keep them
    wr(A_FTC, 32'h0);
    wr(A_NPTS, 32'h3);
    wr(A_PIN + 8'h4, 32'h3E8);
    wr(A_PDSP + 8'h4, 32'h7D0);
    wr(A_PIN + 8'h8, 32'h7D0);
    wr(A_PDSP + 8'h8, 32'h9C4);
    run("interp", 24'h1F4, 24'h3E8);
    run("interp2", 24'h5DC, 24'h8CA);
    run("extrap", 24'hBB8, 24'hBB8);
    run("range", 24'h7530, 24'h2CEC);
    wr(A_PDSP + 8'h8, 32'h7530);
    run("spread", 24'h4E20, 24'h7FFF);
    wr(A_ROUND, 32'h2);
    run("spread2", 24'h4E20, 24'hFFFE);
    run("spread3", -24'sh4E20, -24'shFFFE);
    wr(A_NPTS, 32'h2);
    wr(A_PDSP + 8'h4, 32'h3E8);
    wr(A_ROUND, 32'h5);
    run("rnd_dn", 24'h7A, 24'h78);
    run("rnd_up", 24'h7B, 24'h7D);
    run("rnd_neg", -24'sh7B, -24'sh7D);
    rdc("pdsp1", A_PDSP + 8'h4, 32'h3E8);
    wr(A_ROUND, 32'h0);
    rdc("round1", A_ROUND, 32'h1);
    wr(A_OFFSET, 32'hFFFFFFCE);
    run("offs", 24'hC8, 24'h96);
    wr(A_OFFSET, 32'h186A0);
    rdc("offs_sat", A_OFFSET, 32'h1869F);
    wr(A_OFFSET, 32'h64);
    run("offs2", 24'hC8, 24'h12C);
    rdc("disp", A_DISP, 32'h12C);
    wr(A_KEY, 32'h4);
    rdc("tare", A_OFFSET, 32'hFFFFFF38);
    run("tared", 24'hC8, 24'h0);
    wr(A_OFFSET, 32'h0);
    run("bypass", 24'h1388, 24'h1388);
    wr(A_FTC, 32'hA);
    wr(A_FBAND, 32'h0);
    run("band0", 24'h2328, 24'h1405);
    wr(A_FBAND, 32'hA);
    run("jump", 24'h2328, 24'h2328);
    run("engage", 24'h2329, 24'h2328);
    wr(A_FTC, 32'h0);
    run("zero", 24'h0, 24'h0);
    wr(A_FTC, 32'hA);
    wr(A_FBAND, 32'h0);
    // Queued back to back, so the model must hold while refused
    repeat (160) i_mis_adc_model.q.push_back(24'h3E8);
    take(got);
    chk("step", 32'(got), 32'h1F);
    repeat (159) take(got);
    chk("settle", {31'h0, got >= 24'sh3DE && got <= 24'sh3E8}, 32'h1);
    wr(A_FTC, 32'h0);
    wr(A_ICE, 32'h2);
    i_mis_adc_model.gap = 3;
    wr(A_CTRL, 32'h6A);
    run("tc_std", 24'h64, 24'h6B);
    chk("dp_std", {29'h0, disp_dp}, 32'h1);
    chk("tscale", {31'h0, temp_scale}, 32'h1);
    chk("shown", {31'h0, scale_shown}, 32'h1);
    wr(A_CTRL, 32'h1AC);
    run("tc_cust", 24'h64, 24'h96);
    chk("dp_cust", {29'h0, disp_dp}, 32'h5);
    chk("tot_dp", {29'h0, tot_dp}, 32'h3);
    chk("hidden", {31'h0, scale_shown}, 32'h0);
    chk("pts_ok", {31'h0, points_needed}, 32'h0);
    wr(A_ICE, 32'h0);
    run("ext_cj", 24'h64, 24'h64);
    wr(A_CTRL, 32'h1);
    run("live", 24'h12C, 24'h12C);
    wr(A_KEY, 32'h1);
    wr(A_KEY, 32'h2);
    rdc("cap0", A_PIN, 32'h12C);
    rdc("skip1", A_PIN + 8'h4, 32'h3E8);
    rdc("style", A_CTRL, 32'h0);
    wr(A_KVAL, 32'h309);
    wr(A_KEY, 32'h1);
    rdc("keyed", A_PIN, 32'h309);
    close_out();
  end
endmodule // testbench
